// ---- ld_decode_pkg.sv ----
// Package with configuration indices, device codes, offsets and carriers.
package ld_decode_pkg;

  // Configuration register indices.
  localparam logic [7:0] IDX_LDN = 8'h07;
  localparam logic [7:0] IDX_ACTIVATE = 8'h30;
  localparam logic [7:0] IDX_BASE_HIGH = 8'h60;
  localparam logic [7:0] IDX_BASE_LOW = 8'h61;
  localparam logic [7:0] IDX_IRQ_SEL = 8'h70;
  localparam logic [7:0] IDX_PWR_CTL = 8'hF8;

  // Logical device numbers.
  localparam logic [3:0] LD_FLOPPY = 4'h0;
  localparam logic [3:0] LD_PP = 4'h3;
  localparam logic [3:0] LD_UART1 = 4'h4;
  localparam logic [3:0] LD_UART2 = 4'h5;
  localparam logic [3:0] LD_KBD = 4'h7;
  localparam logic [3:0] LD_ACPI = 4'hA;

  // Base ranges.
  localparam logic [11:0] BASE_MIN_IO = 12'h0100;
  localparam logic [11:0] BASE_MAX_8 = 12'h0FF8;
  localparam logic [11:0] BASE_MAX_4 = 12'h0FFC;
  localparam logic [11:0] BASE_MAX_ACPI = 12'h0FE7;
  localparam logic [11:0] ACPI_SPAN = 12'h0018;

  // Fixed keyboard addresses.
  localparam logic [11:0] KBD_DATA_ADDR = 12'h0060;
  localparam logic [11:0] KBD_CMD_ADDR = 12'h0064;

  // Parallel port extended block offsets.
  localparam logic [11:0] PP_EXT_OFS = 12'h0400;
  localparam logic [11:0] PP_CFGB_OFS = 12'h0401;
  localparam logic [11:0] PP_ECR_OFS = 12'h0402;

  // Device register bit positions.
  localparam int FLOPPY_DMA_IRQ_EN_BIT = 3;
  localparam int PP_IRQ_EN_BIT = 4;
  localparam int PP_SERVICE_BIT = 2;
  localparam int UART_AUX_TWO_BIT = 3;

  // Local register select codes inside a device window.
  typedef enum logic [4:0] {
    SEL_NONE,
    SEL_FLOPPY_STATUS_A, SEL_FLOPPY_STATUS_B, SEL_FLOPPY_DIGITAL_OUTPUT,
    SEL_FLOPPY_TAPE_SELECT, SEL_FLOPPY_MAIN_STATUS_RATE_SELECT,
    SEL_FLOPPY_DATA_QUEUE, SEL_FLOPPY_DIGITAL_IN_CONFIG_CTL,
    SEL_PP_DATA_ADDR_QUEUE, SEL_PP_STATUS, SEL_PP_CONTROL, SEL_PP_EPP_ADDR,
    SEL_PP_EPP_DATA, SEL_PP_DATA_QUEUE_CFG_A, SEL_PP_CONFIG_B, SEL_PP_ECR,
    SEL_UART_RX_TX_BUFFER, SEL_UART_INT_ENABLE, SEL_UART_INT_ID_QUEUE_CTL,
    SEL_UART_LINE_CONTROL, SEL_UART_MODEM, SEL_UART_LINE_STATUS,
    SEL_UART_SCRATCH, SEL_KBD_DATA, SEL_KBD_CMD_STATUS, SEL_ACPI
  } reg_sel_t;

  typedef enum logic [2:0] {
    DEV_NONE, DEV_FLOPPY, DEV_PP, DEV_UART1, DEV_UART2, DEV_KBD, DEV_ACPI
  } dev_t;

  // Result of decoding one host I/O access.
  typedef struct packed {
    logic hit;
    dev_t dev;
    reg_sel_t sel;
    logic [1:0] lane;
  } decode_t;

  // Interrupt-enable conditions reported by each device core except ACPI.
  typedef struct packed {
    logic floppy_dig_out_b3;
    logic pp_control_b4;
    logic pp_ecr_b2;
    logic pp_ecp_mode;
    logic pp_irq_on_mode;
    logic [3:0] uart1_ier;
    logic uart1_aux2;
    logic [3:0] uart2_ier;
    logic uart2_aux2;
    logic kbd_irq_en;
  } irq_cond_t;

endpackage

// ---- logical_device_decode_irq_route.sv ----
// Relocatable I/O decode (keyboard at fixed addresses) and interrupt-line routing for the logical devices.
`timescale 1ns/1ps
module logical_device_decode_irq_route
  import ld_decode_pkg::*;
#(
  parameter int NUM_IRQ = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Configuration register port.
  input wire logic [7:0] cfg_addr_i,
  input wire logic [7:0] cfg_wdata_i,
  input wire logic cfg_we_i,
  input wire logic cfg_re_i,
  output logic [7:0] cfg_rdata_o,
  // Host I/O address and device status.
  input wire logic [15:0] io_addr_i,
  input wire logic io_cycle_i,
  input wire irq_cond_t irq_cond_i,
  input wire logic [5:0] dev_irq_i,
  // Decode result.
  output decode_t decode_o,
  // Interrupt request pins; enable low means driven.
  output logic [NUM_IRQ-1:0] irq_o,
  output logic [NUM_IRQ-1:0] irq_oe_n_o,
  output logic [NUM_IRQ-1:0] irq_level_low_o
);

  localparam int ND = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Configuration registers, one set per logical device.

  logic [3:0] ldn_q, ldn_d;
  logic [ND-1:0] active_q, active_d;
  logic [ND-1:0][15:0] base_q, base_d;
  logic [ND-1:0][3:0] irq_sel_q, irq_sel_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] cur;
  logic cur_ok;

  always_comb begin
    cur_ok = 1'b1;
    unique case (ldn_q)
      LD_FLOPPY: cur = 3'd0;
      LD_PP: cur = 3'd1;
      LD_UART1: cur = 3'd2;
      LD_UART2: cur = 3'd3;
      LD_KBD: cur = 3'd4;
      LD_ACPI: cur = 3'd5;
      default: begin
        cur = 3'd0;
        cur_ok = 1'b0;
      end
    endcase
  end

  always_comb begin
    ldn_d = ldn_q;
    active_d = active_q;
    base_d = base_q;
    irq_sel_d = irq_sel_q;
    rdata_d = 8'h00;
    if (cfg_we_i) begin
      if (cfg_addr_i == IDX_LDN) begin
        ldn_d = cfg_wdata_i[3:0];
      end else if (cur_ok) begin
        unique case (cfg_addr_i)
          IDX_ACTIVATE, IDX_PWR_CTL: active_d[cur] = cfg_wdata_i[0];
          IDX_BASE_HIGH: if (cur != 3'd4) begin
            base_d[cur][15:8] = cfg_wdata_i;
          end
          IDX_BASE_LOW: if (cur != 3'd4) begin
            base_d[cur][7:0] = cfg_wdata_i;
          end
          IDX_IRQ_SEL: irq_sel_d[cur] = cfg_wdata_i[3:0];
          default: ;
        endcase
      end
    end
    if (cfg_re_i) begin
      if (cfg_addr_i == IDX_LDN) begin
        rdata_d = {4'h0, ldn_q};
      end else if (cur_ok) begin
        unique case (cfg_addr_i)
          IDX_ACTIVATE, IDX_PWR_CTL: rdata_d = {7'h00, active_q[cur]};
          IDX_BASE_HIGH: rdata_d = base_q[cur][15:8];
          IDX_BASE_LOW: rdata_d = base_q[cur][7:0];
          IDX_IRQ_SEL: rdata_d = {4'h0, irq_sel_q[cur]};
          default: rdata_d = 8'h00;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ldn_q <= 4'h0;
      active_q <= '0;
      base_q <= '0;
      irq_sel_q <= '0;
      rdata_q <= 8'h00;
    end else begin
      ldn_q <= ldn_d;
      active_q <= active_d;
      base_q <= base_d;
      irq_sel_q <= irq_sel_d;
      rdata_q <= rdata_d;
    end
  end

  assign cfg_rdata_o = rdata_q;

  ////////////////////////////////////////////////////////////////////////////
  // Base range checks and address match.

  logic [11:0] a;
  logic [ND-1:0][11:0] b;
  logic [ND-1:0] valid;
  logic [11:0] acpi_ofs;
  logic pp8;

  assign a = io_addr_i[11:0];
  assign pp8 = (b[1][2] == 1'b0);
  assign acpi_ofs = a - b[5];

  always_comb begin
    for (int i = 0; i < ND; i++) begin
      b[i] = base_q[i][11:0];
    end
    // Eight-byte devices, then the four-byte parallel port, keyboard and ACPI.
    valid[0] = b[0] >= BASE_MIN_IO && b[0] <= BASE_MAX_8 &&
               b[0][2:0] == 3'b000;
    valid[2] = b[2] >= BASE_MIN_IO && b[2] <= BASE_MAX_8 &&
               b[2][2:0] == 3'b000;
    valid[3] = b[3] >= BASE_MIN_IO && b[3] <= BASE_MAX_8 &&
               b[3][2:0] == 3'b000;
    valid[1] = b[1] >= BASE_MIN_IO && b[1] <= BASE_MAX_4 &&
               b[1][1:0] == 2'b00;
    valid[4] = 1'b1;
    valid[5] = b[5] <= BASE_MAX_ACPI &&
               (b[5] % ACPI_SPAN) == 12'h000;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Access decode.

  decode_t dec_d, dec_q;

  always_comb begin
    dec_d = '{hit: 1'b0, dev: DEV_NONE, sel: SEL_NONE, lane: 2'b00};
    if (io_cycle_i) begin
      if (active_q[0] && valid[0] && a[11:3] == b[0][11:3]) begin
        dec_d.dev = DEV_FLOPPY;
        unique case (a[2:0])
          3'd0: dec_d.sel = SEL_FLOPPY_STATUS_A;
          3'd1: dec_d.sel = SEL_FLOPPY_STATUS_B;
          3'd2: dec_d.sel = SEL_FLOPPY_DIGITAL_OUTPUT;
          3'd3: dec_d.sel = SEL_FLOPPY_TAPE_SELECT;
          3'd4: dec_d.sel = SEL_FLOPPY_MAIN_STATUS_RATE_SELECT;
          3'd5: dec_d.sel = SEL_FLOPPY_DATA_QUEUE;
          3'd6: dec_d.sel = SEL_NONE;
          3'd7: dec_d.sel = SEL_FLOPPY_DIGITAL_IN_CONFIG_CTL;
        endcase
      end else if (active_q[1] && valid[1]) begin
        if (a[11:2] == b[1][11:2]) begin
          dec_d.dev = DEV_PP;
          unique case (a[1:0])
            2'd0: dec_d.sel = SEL_PP_DATA_ADDR_QUEUE;
            2'd1: dec_d.sel = SEL_PP_STATUS;
            2'd2: dec_d.sel = SEL_PP_CONTROL;
            2'd3: dec_d.sel = pp8 ? SEL_PP_EPP_ADDR : SEL_NONE;
          endcase
        end else if (pp8 && a[11:2] == (b[1][11:2] + 10'd1)) begin
          dec_d.dev = DEV_PP;
          dec_d.sel = SEL_PP_EPP_DATA;
          dec_d.lane = a[1:0];
        end else if (a == b[1] + PP_EXT_OFS) begin
          dec_d.dev = DEV_PP;
          dec_d.sel = SEL_PP_DATA_QUEUE_CFG_A;
        end else if (a == b[1] + PP_CFGB_OFS) begin
          dec_d.dev = DEV_PP;
          dec_d.sel = SEL_PP_CONFIG_B;
        end else if (a == b[1] + PP_ECR_OFS) begin
          dec_d.dev = DEV_PP;
          dec_d.sel = SEL_PP_ECR;
        end
      end
      if (dec_d.dev == DEV_NONE) begin
        for (int u = 2; u <= 3; u++) begin
          if (dec_d.dev == DEV_NONE && active_q[u] && valid[u] &&
              a[11:3] == b[u][11:3]) begin
            dec_d.dev = (u == 2) ? DEV_UART1 : DEV_UART2;
            unique case (a[2:0])
              3'd0: dec_d.sel = SEL_UART_RX_TX_BUFFER;
              3'd1: dec_d.sel = SEL_UART_INT_ENABLE;
              3'd2: dec_d.sel = SEL_UART_INT_ID_QUEUE_CTL;
              3'd3: dec_d.sel = SEL_UART_LINE_CONTROL;
              3'd4: dec_d.sel = SEL_UART_MODEM;
              3'd5: dec_d.sel = SEL_UART_LINE_STATUS;
              3'd6: dec_d.sel = SEL_UART_MODEM;
              3'd7: dec_d.sel = SEL_UART_SCRATCH;
            endcase
          end
        end
      end
      if (dec_d.dev == DEV_NONE && active_q[4]) begin
        if (a == KBD_DATA_ADDR) begin
          dec_d.dev = DEV_KBD;
          dec_d.sel = SEL_KBD_DATA;
        end else if (a == KBD_CMD_ADDR) begin
          dec_d.dev = DEV_KBD;
          dec_d.sel = SEL_KBD_CMD_STATUS;
        end
      end
      if (dec_d.dev == DEV_NONE && active_q[5] && valid[5] &&
          a >= b[5] && acpi_ofs < ACPI_SPAN) begin
        dec_d.dev = DEV_ACPI;
        dec_d.sel = SEL_ACPI;
        dec_d.lane = acpi_ofs[1:0];
      end
      dec_d.hit = (dec_d.dev != DEV_NONE) && (dec_d.sel != SEL_NONE);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dec_q <= '{hit: 1'b0, dev: DEV_NONE, sel: SEL_NONE, lane: 2'b00};
    end else begin
      dec_q <= dec_d;
    end
  end

  assign decode_o = dec_q;

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt routing.

  logic [ND-1:0] dev_en;
  logic [NUM_IRQ-1:0] irq_d, irq_q, oe_n_d, oe_n_q, low_d, low_q;

  always_comb begin
    dev_en[0] = irq_cond_i.floppy_dig_out_b3;
    dev_en[1] = irq_cond_i.pp_control_b4 &&
                (!irq_cond_i.pp_ecp_mode || !irq_cond_i.pp_ecr_b2);
    dev_en[2] = |irq_cond_i.uart1_ier && irq_cond_i.uart1_aux2;
    dev_en[3] = |irq_cond_i.uart2_ier && irq_cond_i.uart2_aux2;
    dev_en[4] = irq_cond_i.kbd_irq_en;
    dev_en[5] = 1'b1;
    irq_d = '0;
    oe_n_d = '1;
    low_d = '0;
    for (int i = 0; i < ND; i++) begin
      if (active_q[i] && valid[i] && irq_sel_q[i] != 4'h0 &&
          dev_en[i]) begin
        oe_n_d[irq_sel_q[i]] = 1'b0;
        irq_d[irq_sel_q[i]] = irq_d[irq_sel_q[i]] | dev_irq_i[i];
        if (i == 1 && irq_cond_i.pp_irq_on_mode) begin
          low_d[irq_sel_q[i]] = 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_q <= '0;
      oe_n_q <= '1;
      low_q <= '0;
    end else begin
      irq_q <= irq_d;
      oe_n_q <= oe_n_d;
      low_q <= low_d;
    end
  end

  assign irq_o = irq_q;
  assign irq_oe_n_o = oe_n_q;
  assign irq_level_low_o = low_q;

endmodule

// ---- ld_route_chk.sv ----
// Port checker for the decode and interrupt routing block.
`timescale 1ns/1ps
module ld_route_chk
  import ld_decode_pkg::*;
#(
  parameter int NUM_IRQ = 16
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Host access and results.
  input wire logic [15:0] io_addr_i,
  input wire logic io_cycle_i,
  input wire decode_t decode_o,
  input wire logic [NUM_IRQ-1:0] irq_oe_n_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_hit(dev_t d);
    decode_o.hit && decode_o.dev == d;
  endsequence
  sequence s_sel(dev_t d, reg_sel_t s);
    s_hit(d) ##0 decode_o.sel == s;
  endsequence
  chk_hit_needs_cycle: assert property (
    !io_cycle_i |=> !decode_o.hit)
    else $error("decode hit without an access");
  chk_line_zero_float: assert property (irq_oe_n_o[0])
    else $error("line zero is driven");
  chk_floppy_out_ofs: assert property (
    s_sel(DEV_FLOPPY, SEL_FLOPPY_DIGITAL_OUTPUT) |->
    $past(io_addr_i[2:0]) == 3'h2) else $error("floppy output offset");
  chk_floppy_base_range: assert property (
    s_hit(DEV_FLOPPY) |-> $past(io_addr_i[11:0]) >= 12'h100)
    else $error("floppy hit below range");
  chk_uart_scratch_ofs: assert property (
    s_sel(DEV_UART1, SEL_UART_SCRATCH) |->
    $past(io_addr_i[2:0]) == 3'h7) else $error("uart scratch offset");
  chk_epp_addr_ofs: assert property (
    s_sel(DEV_PP, SEL_PP_EPP_ADDR) |->
    $past(io_addr_i[2:0]) == 3'h3) else $error("epp address offset");
  chk_epp_data_lane: assert property (
    s_sel(DEV_PP, SEL_PP_EPP_DATA) |-> $past(io_addr_i[2]) &&
    decode_o.lane == $past(io_addr_i[1:0])) else $error("epp lane");
  chk_pp_ecr_ofs: assert property (
    s_sel(DEV_PP, SEL_PP_ECR) |->
    $past(io_addr_i[1:0]) == 2'h2) else $error("ecr offset");
  chk_kbd_fixed_addr: assert property (
    s_hit(DEV_KBD) |->
    $past(io_addr_i[11:0]) inside {12'h060, 12'h064})
    else $error("keyboard hit at a moved address");
endmodule
bind logical_device_decode_irq_route ld_route_chk #(.NUM_IRQ(NUM_IRQ))
  u_ld_route_chk (.clk_i(clk_i), .rst_i(rst_i), .io_addr_i(io_addr_i),
  .io_cycle_i(io_cycle_i), .decode_o(decode_o), .irq_oe_n_o(irq_oe_n_o));

// ---- ld_host_model.sv ----
// Host bus master model issuing single I/O cycles.
`timescale 1ns/1ps
module ld_host_model (
  // Request from the bench.
  input wire logic go_i,
  input wire logic [15:0] addr_i,
  // Host bus.
  output logic io_cycle_o,
  output logic [15:0] io_addr_o
);
  logic [15:0] last_q = 16'h0000;
  always @(negedge go_i) last_q = addr_i;
  // Idle address shows the inverse of the last one, never a stale match.
  assign io_addr_o = go_i ? addr_i : ~last_q;
  assign io_cycle_o = go_i;
endmodule

// ---- test_logical_device_decode_irq_route.sv ----
// Self-checking bench for the decode and interrupt routing block.
`timescale 1ns/1ps
module test_logical_device_decode_irq_route;
  import ld_decode_pkg::*;
  logic clk_i = 0, rst_i = 1, we = 0, re = 0, go = 0;
  logic [7:0] ca = 0, cd = 0, rd;
  logic [15:0] ga = 0, ia, iq, oen, lvl, r;
  logic [15:0] lfsr_q = 16'h5d2a;
  logic ic;
  logic [5:0] dirq = 0;
  logic [11:0] b;
  logic [3:0] ln;
  irq_cond_t cond = '0;
  irq_cond_t cv = '0;
  decode_t dec;
  int num_errors = 0, checks = 0, cyc = 0;
  reg_sel_t fs[8] = '{SEL_FLOPPY_STATUS_A, SEL_FLOPPY_STATUS_B,
    SEL_FLOPPY_DIGITAL_OUTPUT, SEL_FLOPPY_TAPE_SELECT,
    SEL_FLOPPY_MAIN_STATUS_RATE_SELECT, SEL_FLOPPY_DATA_QUEUE, SEL_NONE,
    SEL_FLOPPY_DIGITAL_IN_CONFIG_CTL};
  reg_sel_t us[8] = '{SEL_UART_RX_TX_BUFFER, SEL_UART_INT_ENABLE,
    SEL_UART_INT_ID_QUEUE_CTL, SEL_UART_LINE_CONTROL, SEL_UART_MODEM,
    SEL_UART_LINE_STATUS, SEL_UART_MODEM, SEL_UART_SCRATCH};
  reg_sel_t ps[8] = '{SEL_PP_DATA_ADDR_QUEUE, SEL_PP_STATUS,
    SEL_PP_CONTROL, SEL_PP_EPP_ADDR, SEL_PP_EPP_DATA, SEL_PP_EPP_DATA,
    SEL_PP_EPP_DATA, SEL_PP_EPP_DATA};
  initial forever #5 clk_i = ~clk_i;
  logical_device_decode_irq_route u_logical_device_decode_irq_route (
    .clk_i(clk_i), .rst_i(rst_i), .cfg_addr_i(ca), .cfg_wdata_i(cd),
    .cfg_we_i(we), .cfg_re_i(re), .cfg_rdata_o(rd), .io_addr_i(ia),
    .io_cycle_i(ic), .irq_cond_i(cond), .dev_irq_i(dirq), .decode_o(dec),
    .irq_o(iq), .irq_oe_n_o(oen), .irq_level_low_o(lvl));
  ld_host_model u_ld_host_model (.go_i(go), .addr_i(ga), .io_cycle_o(ic),
    .io_addr_o(ia));
  function automatic logic [15:0] nxt();
    lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
    return lfsr_q;
  endfunction
  // Expected enables: only the selected line is driven, with its enable held low.
  function automatic logic [15:0] oe_mask(input logic [3:0] l, logic dr);
    return dr ? ~(16'h0001 << l) : 16'hffff;
  endfunction
  task automatic results();
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      results();
    end
  end
  task automatic cmp(input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_i);
    we <= 1;
    ca <= a;
    cd <= d;
    @(posedge clk_i);
    we <= 0;
  endtask
  task automatic rdc(input logic [7:0] a, e);
    @(posedge clk_i);
    re <= 1;
    ca <= a;
    @(posedge clk_i);
    re <= 0;
    #1 cmp(rd, e);
  endtask
  task automatic setup(input logic [3:0] d, input logic [11:0] bs, logic a);
    wr(IDX_LDN, {4'h0, d});
    wr(IDX_BASE_HIGH, {4'h0, bs[11:8]});
    wr(IDX_BASE_LOW, bs[7:0]);
    wr(IDX_ACTIVATE, {7'h00, a});
  endtask
  // Upper address nibble is random so that only the low twelve bits matter.
  task automatic io(input logic [11:0] a, logic h, dev_t d, reg_sel_t s);
    logic [15:0] x;
    x = nxt();
    @(posedge clk_i);
    go <= 1;
    ga <= {x[15:12], a};
    @(posedge clk_i);
    go <= 0;
    #1;
    if (h)
      cmp({dec.hit, dec.dev, dec.sel}, {h, d, s});
    else
      cmp(dec.hit, 0);
  endtask
  task automatic scan(input dev_t d, logic [11:0] bs, reg_sel_t t[8]);
    for (int o = 0; o < 8; o++)
      if (t[o] != SEL_NONE || d == DEV_FLOPPY)
        io({bs[11:3], 3'(o)}, t[o] != SEL_NONE, d, t[o]);
  endtask
  task automatic irqc(input irq_cond_t c, logic [3:0] l, logic dr, int k);
    logic [15:0] x;
    x = nxt();
    @(posedge clk_i);
    cond <= c;
    dirq <= x[5:0];
    repeat (2) @(posedge clk_i);
    #1 cmp(oen, oe_mask(l, dr));
    if (dr)
      cmp(iq[l], dirq[k]);
  endtask
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    #1 cmp(oen, 16'hffff);
    wr(IDX_LDN, {4'h0, LD_FLOPPY});
    rdc(IDX_IRQ_SEL, 8'h00);
    r = nxt();
    b = {r[11:3], 3'h0} | 12'h100;
    ln = (r[15:12] == 4'h0) ? 4'h9 : r[15:12];
    setup(LD_FLOPPY, b, 1);
    rdc(IDX_BASE_HIGH, {4'h0, b[11:8]});
    rdc(IDX_BASE_LOW, b[7:0]);
    scan(DEV_FLOPPY, b, fs);
    wr(IDX_IRQ_SEL, {4'h0, ln});
    rdc(IDX_IRQ_SEL, {4'h0, ln});
    cv.floppy_dig_out_b3 = 1;
    irqc(cv, ln, 1, 0);
    cmp(lvl[ln], 0);
    irqc('0, ln, 0, 0);
    wr(IDX_IRQ_SEL, 8'h00);
    irqc(cv, ln, 0, 0);
    setup(LD_FLOPPY, 12'h0f8, 1);
    io(12'h0fa, 0, DEV_FLOPPY, SEL_NONE);
    setup(LD_FLOPPY, b, 0);
    io({b[11:3], 3'h2}, 0, DEV_FLOPPY, SEL_NONE);
    wr(IDX_PWR_CTL, 8'h01);
    rdc(IDX_ACTIVATE, 8'h01);
    io({b[11:3], 3'h2}, 1, DEV_FLOPPY, SEL_FLOPPY_DIGITAL_OUTPUT);
    wr(IDX_ACTIVATE, 8'h00);
    rdc(IDX_PWR_CTL, 8'h00);
    r = nxt();
    b = {r[11:3], 3'h0} | 12'h100;
    setup(LD_UART1, b, 1);
    scan(DEV_UART1, b, us);
    wr(IDX_IRQ_SEL, {4'h0, ln});
    cv = '0;
    cv.uart1_ier = r[15:12] | 4'h1;
    cv.uart1_aux2 = 1;
    irqc(cv, ln, 1, 2);
    cv.uart1_aux2 = 0;
    irqc(cv, ln, 0, 2);
    cv.uart1_aux2 = 1;
    cv.uart1_ier = 4'h0;
    irqc(cv, ln, 0, 2);
    wr(IDX_ACTIVATE, 8'h00);
    r = nxt();
    b = {2'h0, r[9:3], 3'h0} | 12'h100;
    setup(LD_PP, b, 1);
    scan(DEV_PP, b, ps);
    io(b + PP_EXT_OFS, 1, DEV_PP, SEL_PP_DATA_QUEUE_CFG_A);
    io(b + PP_CFGB_OFS, 1, DEV_PP, SEL_PP_CONFIG_B);
    io(b + PP_ECR_OFS, 1, DEV_PP, SEL_PP_ECR);
    setup(LD_PP, b | 12'h004, 1);
    io(b | 12'h004, 1, DEV_PP, SEL_PP_DATA_ADDR_QUEUE);
    io(b | 12'h007, 0, DEV_PP, SEL_NONE);
    wr(IDX_IRQ_SEL, {4'h0, ln});
    cv = '0;
    cv.pp_control_b4 = 1;
    irqc(cv, ln, 1, 1);
    cmp(lvl[ln], 0);
    cv.pp_ecp_mode = 1;
    cv.pp_irq_on_mode = 1;
    cv.pp_ecr_b2 = 1;
    irqc(cv, ln, 0, 1);
    cv.pp_ecr_b2 = 0;
    irqc(cv, ln, 1, 1);
    cmp(lvl[ln], 1);
    wr(IDX_LDN, {4'h0, LD_KBD});
    wr(IDX_BASE_HIGH, 8'h03);
    rdc(IDX_BASE_HIGH, 8'h00);
    rdc(8'h40, 8'h00);
    wr(IDX_ACTIVATE, 8'h01);
    io(KBD_DATA_ADDR, 1, DEV_KBD, SEL_KBD_DATA);
    io(KBD_CMD_ADDR, 1, DEV_KBD, SEL_KBD_CMD_STATUS);
    setup(LD_ACPI, 12'h030, 1);
    io(12'h031, 1, DEV_ACPI, SEL_ACPI);
    cmp(dec.lane, 2'h1);
    @(posedge clk_i);
    rst_i <= 1;
    @(posedge clk_i);
    rst_i <= 0;
    #1 cmp(oen, 16'hffff);
    wr(IDX_LDN, {4'h0, LD_PP});
    rdc(IDX_IRQ_SEL, 8'h00);
    results();
  end
endmodule
